/* File: verilog/bssb_pkg.sv */
// package: opcode patterns, field positions and sizes for the bit-set / subroutine-branch block
package bssb_pkg;
  localparam logic [9:0] bssb_set_imm_pattern = 10'h023;
  localparam logic [3:0] bssb_set_reg_top = 4'h0;
  localparam logic [2:0] bssb_set_reg_mid = 3'h7;
  localparam logic [7:0] bssb_branch_pattern = 8'h61;
  localparam logic [7:0] bssb_ext_upper_zero = 8'h00;
  localparam logic [7:0] bssb_disp_word_code = 8'h00;
  localparam logic [7:0] bssb_disp_long_code = 8'hff;
  localparam logic [2:0] bssb_mode_data_reg = 3'h0;
  localparam logic [2:0] bssb_mode_addr_reg = 3'h1;
  localparam logic [2:0] bssb_mode_absolute = 3'h7;
  localparam logic [2:0] bssb_reg_abs_long = 3'h1;
  localparam logic [31:0] bssb_stack_step = 32'h0000_0004;
  localparam logic [31:0] bssb_pc_step = 32'h0000_0002;
  localparam int bssb_mode_lsb = 3;
  localparam int bssb_dreg_lsb = 9;
  localparam int bssb_reg_bitnum_mask = 31;
  localparam int bssb_mem_bitnum_mask = 7;
  typedef enum logic [1:0] {
    bssb_size_byte_type_e,
    bssb_size_word_type_e,
    bssb_size_long_type_e
  } bssb_size_type;
endpackage

/* File: verilog/bssb_decode_if.sv */
// interface: decoded fields passed from the opcode decoder to the sequencer
`timescale 1ns/100ps
`default_nettype none
interface bssb_decode_if;
  logic is_set_imm;
  logic is_set_reg;
  logic is_branch;
  logic ea_ok;
  logic [2:0] ea_reg;
  logic [2:0] bitnum_reg;
  logic [7:0] disp8;
  modport dec (output is_set_imm, is_set_reg, is_branch, ea_ok, ea_reg, bitnum_reg, disp8);
  modport seq (input is_set_imm, is_set_reg, is_branch, ea_ok, ea_reg, bitnum_reg, disp8);
endinterface
`default_nettype wire

/* File: verilog/bssb_decoder.sv */
// module: combinational opcode decoder for the two instructions
`timescale 1ns/100ps
`default_nettype none
module bssb_decoder (
  input wire logic [15:0] opcode,
  bssb_decode_if.dec dec
);
  logic [2:0] mode;
  logic [2:0] reg_f;
  always_comb begin
    mode = opcode[bssb_pkg::bssb_mode_lsb +: 3];
    reg_f = opcode[2:0];
    dec.is_set_imm = (opcode[15:6] == bssb_pkg::bssb_set_imm_pattern);
    dec.is_set_reg = (opcode[15:12] == bssb_pkg::bssb_set_reg_top)
        && (opcode[8:6] == bssb_pkg::bssb_set_reg_mid);
    dec.is_branch = (opcode[15:8] == bssb_pkg::bssb_branch_pattern);
    // data alterable only: no address register, no immediate, no pc-relative
    dec.ea_ok = (mode != bssb_pkg::bssb_mode_addr_reg)
        && ((mode != bssb_pkg::bssb_mode_absolute) || (reg_f <= bssb_pkg::bssb_reg_abs_long));
    dec.ea_reg = reg_f;
    dec.bitnum_reg = opcode[bssb_pkg::bssb_dreg_lsb +: 3];
    dec.disp8 = opcode[7:0];
  end
endmodule
`default_nettype wire

/* File: verilog/bssb_core.sv */
// module: sequencer executing test-and-set-bit and subroutine branch
// What this block does
// - sample destination bit, then set it
// - zero flag is inverse bit; others kept
// - data register: 32 bits, modulo 32
// - memory destination: byte, bit modulo 8
// - bit zero is least significant
// - immediate form opcode, bit number follows
// - extension word: upper byte zero, number low
// - register form opcode layout
// - only data alterable destinations accepted
// - stack pointer minus four, push return
// - target is opcode address plus two plus displacement
// - field zero word, all ones long displacement
// - branch opcode is 01100001 plus displacement
// - zero field takes word extension
`timescale 1ns/100ps
`default_nettype none
module bssb_core (
  input wire logic clk,
  input wire logic resetn,
  input wire logic op_valid,
  input wire logic [15:0] op_word,
  input wire logic [31:0] op_addr,
  input wire logic ext_valid,
  input wire logic [15:0] ext_word,
  input wire logic [31:0] ea_addr,
  input wire logic [31:0] rf_rdata_a,
  input wire logic [31:0] rf_rdata_b,
  input wire logic [31:0] stack_pointer,
  input wire logic [4:0] ccr_in,
  input wire logic mem_done,
  input wire logic [7:0] mem_rdata,
  output logic op_ready,
  output logic ext_req,
  output logic illegal,
  output logic [2:0] rf_raddr_a,
  output logic [2:0] rf_raddr_b,
  output logic rf_we,
  output logic [2:0] rf_waddr,
  output logic [31:0] rf_wdata,
  output logic sp_we,
  output logic [31:0] sp_wdata,
  output logic mem_req,
  output logic mem_write,
  output logic [1:0] mem_size,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  output logic ccr_we,
  output logic [4:0] ccr_out,
  output logic pc_we,
  output logic [31:0] pc_out,
  output logic done
);
  //////////////////////////////////////////////////////////////////////////////
  typedef enum logic [3:0] {
    st_idle, st_ext_bit, st_reg_op, st_mem_read, st_mem_write,
    st_disp_hi, st_disp_lo, st_push, st_branch, st_finish
  } bssb_state_type;

  bssb_decode_if dec_bus ();
  bssb_decoder u_dec (
    .opcode(op_word),
    .dec(dec_bus)
  );

  bssb_state_type state_ff, nxt_state;
  logic [15:0] opc_ff, nxt_opc;
  logic [31:0] pc_ff, nxt_pc;
  logic [31:0] disp_ff, nxt_disp;
  logic [5:0] bitnum_ff, nxt_bitnum;
  logic [31:0] addr_ff, nxt_addr;
  logic op_ready_ff, nxt_op_ready;
  logic ext_req_ff, nxt_ext_req;
  logic illegal_ff, nxt_illegal;
  logic [2:0] raddr_a_ff, nxt_raddr_a;
  logic [2:0] raddr_b_ff, nxt_raddr_b;
  logic rf_we_ff, nxt_rf_we;
  logic [2:0] rf_waddr_ff, nxt_rf_waddr;
  logic [31:0] rf_wdata_ff, nxt_rf_wdata;
  logic sp_we_ff, nxt_sp_we;
  logic [31:0] sp_wdata_ff, nxt_sp_wdata;
  logic mem_req_ff, nxt_mem_req;
  logic mem_write_ff, nxt_mem_write;
  logic [1:0] mem_size_ff, nxt_mem_size;
  logic [31:0] mem_addr_ff, nxt_mem_addr;
  logic [31:0] mem_wdata_ff, nxt_mem_wdata;
  logic ccr_we_ff, nxt_ccr_we;
  logic [4:0] ccr_ff, nxt_ccr;
  logic pc_we_ff, nxt_pc_we;
  logic [31:0] pc_out_ff, nxt_pc_out;
  logic done_ff, nxt_done;
  logic [4:0] reg_bit;
  logic [2:0] mem_bit;
  logic [31:0] reg_mask;
  logic [7:0] mem_mask;

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    // bit index masked by operand width; bit 0 is the lsb
    reg_bit = bitnum_ff[4:0] & 5'(bssb_pkg::bssb_reg_bitnum_mask);
    mem_bit = bitnum_ff[2:0] & 3'(bssb_pkg::bssb_mem_bitnum_mask);
    reg_mask = 32'h0000_0001 << reg_bit;
    mem_mask = 8'h01 << mem_bit;
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_opc = opc_ff;
    nxt_pc = pc_ff;
    nxt_disp = disp_ff;
    nxt_bitnum = bitnum_ff;
    nxt_addr = addr_ff;
    nxt_op_ready = 1'b0;
    nxt_ext_req = 1'b0;
    nxt_illegal = 1'b0;
    nxt_raddr_a = raddr_a_ff;
    nxt_raddr_b = raddr_b_ff;
    nxt_rf_we = 1'b0;
    nxt_rf_waddr = rf_waddr_ff;
    nxt_rf_wdata = rf_wdata_ff;
    nxt_sp_we = 1'b0;
    nxt_sp_wdata = sp_wdata_ff;
    nxt_mem_req = mem_req_ff;
    nxt_mem_write = mem_write_ff;
    nxt_mem_size = mem_size_ff;
    nxt_mem_addr = mem_addr_ff;
    nxt_mem_wdata = mem_wdata_ff;
    nxt_ccr_we = 1'b0;
    nxt_ccr = ccr_ff;
    nxt_pc_we = 1'b0;
    nxt_pc_out = pc_out_ff;
    nxt_done = 1'b0;
    unique case (state_ff)
      st_idle: begin
        nxt_op_ready = 1'b1;
        if (op_valid && op_ready_ff) begin
          nxt_op_ready = 1'b0;
          nxt_opc = op_word;
          nxt_pc = op_addr + bssb_pkg::bssb_pc_step;
          nxt_addr = ea_addr;
          nxt_raddr_a = dec_bus.ea_reg;
          nxt_raddr_b = dec_bus.bitnum_reg;
          if (dec_bus.is_branch) begin
            nxt_disp = {{24{dec_bus.disp8[7]}}, dec_bus.disp8};
            if (dec_bus.disp8 == bssb_pkg::bssb_disp_word_code) begin
              nxt_state = st_disp_lo;
              nxt_ext_req = 1'b1;
            end else if (dec_bus.disp8 == bssb_pkg::bssb_disp_long_code) begin
              nxt_state = st_disp_hi;
              nxt_ext_req = 1'b1;
            end else begin
              nxt_state = st_push;
            end
          end else if ((dec_bus.is_set_imm || dec_bus.is_set_reg) && dec_bus.ea_ok) begin
            if (dec_bus.is_set_imm) begin
              nxt_state = st_ext_bit;
              nxt_ext_req = 1'b1;
            end else begin
              nxt_state = st_reg_op;
            end
          end else begin
            nxt_illegal = 1'b1;
            nxt_state = st_finish;
          end
        end
      end
      st_ext_bit: begin
        nxt_ext_req = 1'b1;
        if (ext_valid) begin
          nxt_ext_req = 1'b0;
          // a nonzero upper byte is not a valid extension
          if (ext_word[15:8] != bssb_pkg::bssb_ext_upper_zero) begin
            nxt_illegal = 1'b1;
            nxt_state = st_finish;
          end else begin
            nxt_bitnum = ext_word[5:0];
            nxt_state = st_reg_op;
          end
        end
      end
      st_reg_op: begin
        // register form reads the bit number now; read ports settled since entry
        if (opc_ff[8]) begin
          nxt_bitnum = rf_rdata_b[5:0];
        end
        if (opc_ff[5:3] == bssb_pkg::bssb_mode_data_reg) begin
          nxt_state = st_mem_write;
          nxt_mem_req = 1'b0;
        end else begin
          nxt_state = st_mem_read;
          nxt_mem_req = 1'b1;
          nxt_mem_write = 1'b0;
          nxt_mem_size = 2'(bssb_pkg::bssb_size_byte_type_e);
          nxt_mem_addr = addr_ff;
        end
      end
      st_mem_read: begin
        if (mem_done) begin
          // test before set: z takes the inverse of the old bit
          nxt_ccr = {ccr_in[4:3], ~|(mem_rdata & mem_mask), ccr_in[1:0]};
          nxt_ccr_we = 1'b1;
          nxt_mem_write = 1'b1;
          nxt_mem_wdata = {24'h00_0000, mem_rdata | mem_mask};
          nxt_state = st_finish;
        end
      end
      st_mem_write: begin
        if (opc_ff[5:3] == bssb_pkg::bssb_mode_data_reg && !mem_req_ff) begin
          nxt_ccr = {ccr_in[4:3], ~|(rf_rdata_a & reg_mask), ccr_in[1:0]};
          nxt_ccr_we = 1'b1;
          nxt_rf_we = 1'b1;
          nxt_rf_waddr = raddr_a_ff;
          nxt_rf_wdata = rf_rdata_a | reg_mask;
          nxt_done = 1'b1;
          nxt_state = st_idle;
        end
      end
      st_disp_hi: begin
        nxt_ext_req = 1'b1;
        if (ext_valid) begin
          nxt_disp = {ext_word, 16'h0000};
          nxt_state = st_disp_lo;
        end
      end
      st_disp_lo: begin
        nxt_ext_req = 1'b1;
        if (ext_valid) begin
          nxt_ext_req = 1'b0;
          if (opc_ff[7:0] == bssb_pkg::bssb_disp_long_code) begin
            nxt_disp = {disp_ff[31:16], ext_word};
          end else begin
            nxt_disp = {{16{ext_word[15]}}, ext_word};
          end
          nxt_state = st_push;
        end
      end
      st_push: begin
        nxt_sp_we = 1'b1;
        nxt_sp_wdata = stack_pointer - bssb_pkg::bssb_stack_step;
        nxt_mem_req = 1'b1;
        nxt_mem_write = 1'b1;
        nxt_mem_size = 2'(bssb_pkg::bssb_size_long_type_e);
        nxt_mem_addr = stack_pointer - bssb_pkg::bssb_stack_step;
        // return address is past any extension words
        if (opc_ff[7:0] == bssb_pkg::bssb_disp_word_code) begin
          nxt_mem_wdata = pc_ff + bssb_pkg::bssb_pc_step;
        end else if (opc_ff[7:0] == bssb_pkg::bssb_disp_long_code) begin
          nxt_mem_wdata = pc_ff + bssb_pkg::bssb_stack_step;
        end else begin
          nxt_mem_wdata = pc_ff;
        end
        nxt_state = st_branch;
      end
      st_branch: begin
        if (mem_done) begin
          nxt_mem_req = 1'b0;
          nxt_pc_we = 1'b1;
          nxt_pc_out = pc_ff + disp_ff;
          nxt_done = 1'b1;
          nxt_state = st_idle;
        end
      end
      st_finish: begin
        // memory write of the set byte completes here
        if (!mem_req_ff || mem_done) begin
          nxt_mem_req = 1'b0;
          nxt_done = 1'b1;
          nxt_state = st_idle;
        end
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_ff <= st_idle;
      opc_ff <= 16'h0000;
      pc_ff <= 32'h0000_0000;
      disp_ff <= 32'h0000_0000;
      bitnum_ff <= 6'h00;
      addr_ff <= 32'h0000_0000;
      op_ready_ff <= 1'b0;
      ext_req_ff <= 1'b0;
      illegal_ff <= 1'b0;
      raddr_a_ff <= 3'h0;
      raddr_b_ff <= 3'h0;
      rf_we_ff <= 1'b0;
      rf_waddr_ff <= 3'h0;
      rf_wdata_ff <= 32'h0000_0000;
      sp_we_ff <= 1'b0;
      sp_wdata_ff <= 32'h0000_0000;
      mem_req_ff <= 1'b0;
      mem_write_ff <= 1'b0;
      mem_size_ff <= 2'h0;
      mem_addr_ff <= 32'h0000_0000;
      mem_wdata_ff <= 32'h0000_0000;
      ccr_we_ff <= 1'b0;
      ccr_ff <= 5'h00;
      pc_we_ff <= 1'b0;
      pc_out_ff <= 32'h0000_0000;
      done_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      opc_ff <= nxt_opc;
      pc_ff <= nxt_pc;
      disp_ff <= nxt_disp;
      bitnum_ff <= nxt_bitnum;
      addr_ff <= nxt_addr;
      op_ready_ff <= nxt_op_ready;
      ext_req_ff <= nxt_ext_req;
      illegal_ff <= nxt_illegal;
      raddr_a_ff <= nxt_raddr_a;
      raddr_b_ff <= nxt_raddr_b;
      rf_we_ff <= nxt_rf_we;
      rf_waddr_ff <= nxt_rf_waddr;
      rf_wdata_ff <= nxt_rf_wdata;
      sp_we_ff <= nxt_sp_we;
      sp_wdata_ff <= nxt_sp_wdata;
      mem_req_ff <= nxt_mem_req;
      mem_write_ff <= nxt_mem_write;
      mem_size_ff <= nxt_mem_size;
      mem_addr_ff <= nxt_mem_addr;
      mem_wdata_ff <= nxt_mem_wdata;
      ccr_we_ff <= nxt_ccr_we;
      ccr_ff <= nxt_ccr;
      pc_we_ff <= nxt_pc_we;
      pc_out_ff <= nxt_pc_out;
      done_ff <= nxt_done;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    op_ready = op_ready_ff;
    ext_req = ext_req_ff;
    illegal = illegal_ff;
    rf_raddr_a = raddr_a_ff;
    rf_raddr_b = raddr_b_ff;
    rf_we = rf_we_ff;
    rf_waddr = rf_waddr_ff;
    rf_wdata = rf_wdata_ff;
    sp_we = sp_we_ff;
    sp_wdata = sp_wdata_ff;
    mem_req = mem_req_ff;
    mem_write = mem_write_ff;
    mem_size = mem_size_ff;
    mem_addr = mem_addr_ff;
    mem_wdata = mem_wdata_ff;
    ccr_we = ccr_we_ff;
    ccr_out = ccr_ff;
    pc_we = pc_we_ff;
    pc_out = pc_out_ff;
    done = done_ff;
  end
endmodule
`default_nettype wire

/* File: testbench/bssb_core_chk.sv */
// checker: port-level rules of the bit-set / subroutine-branch core
`timescale 1ns/100ps
`default_nettype none
module bssb_core_chk (
  input wire logic clk,
  input wire logic resetn,
  input wire logic op_valid,
  input wire logic [15:0] op_word,
  input wire logic [31:0] stack_pointer,
  input wire logic [4:0] ccr_in,
  input wire logic mem_done,
  input wire logic op_ready,
  input wire logic illegal,
  input wire logic rf_we,
  input wire logic sp_we,
  input wire logic [31:0] sp_wdata,
  input wire logic mem_req,
  input wire logic mem_write,
  input wire logic [1:0] mem_size,
  input wire logic [31:0] mem_addr,
  input wire logic ccr_we,
  input wire logic [4:0] ccr_out,
  input wire logic pc_we,
  input wire logic done
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////////////////
  property p_done;
    done |=> !done && op_ready;
  endproperty
  a_done: assert property (p_done) else $error("done not a pulse or ready late");
  property p_take;
    op_valid && op_ready |=> !op_ready;
  endproperty
  a_take: assert property (p_take) else $error("ready stayed up after take");
  // data-register destination in register form never waits on memory
  property p_reg_lat;
    op_valid && op_ready && op_word[15:12] == 4'h0 && op_word[8:3] == 6'h38 |-> ##3 rf_we && ccr_we && done;
  endproperty
  a_reg_lat: assert property (p_reg_lat) else $error("register set late");
  property p_flags;
    ccr_we |-> ccr_out[4:3] == ccr_in[4:3] && ccr_out[1:0] == ccr_in[1:0];
  endproperty
  a_flags: assert property (p_flags) else $error("flag other than zero changed");
  property p_push;
    sp_we |-> sp_wdata == stack_pointer - 32'h0000_0004 && mem_req && mem_write && mem_size == 2'h2
      && mem_addr == sp_wdata;
  endproperty
  a_push: assert property (p_push) else $error("push address or size wrong");
  property p_rmw;
    mem_done && mem_req && !mem_write && mem_size == 2'h0 |=> mem_req && mem_write && ccr_we && $stable(mem_addr);
  endproperty
  a_rmw: assert property (p_rmw) else $error("byte write does not follow read");
  property p_hold;
    mem_req && !mem_done |=> mem_req && $stable(mem_addr) && $stable(mem_write);
  endproperty
  a_hold: assert property (p_hold) else $error("memory request dropped early");
  property p_illegal;
    illegal |-> !rf_we && !mem_req && !ccr_we ##1 done;
  endproperty
  a_illegal: assert property (p_illegal) else $error("refused op wrote or hung");
  property p_target;
    pc_we |-> done && !ccr_we;
  endproperty
  a_target: assert property (p_target) else $error("branch target not at done");
endmodule
bind bssb_core bssb_core_chk u_bssb_core_chk (.*);
`default_nettype wire

/* File: testbench/bssb_core_tb.sv */
// testbench: directed scenarios for the bit-set / subroutine-branch core
`timescale 1ns/100ps
`default_nettype none
module bssb_core_tb;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic op_valid = 1'b0;
  logic [15:0] op_word = 16'h0000;
  logic [31:0] op_addr = 32'h0000_1000;
  logic ext_valid = 1'b0;
  logic [15:0] ext_word = 16'h0000;
  logic [31:0] ea_addr = 32'h0000_2345;
  logic [31:0] stack_pointer = 32'h0000_8000;
  logic [4:0] ccr_in = 5'h00;
  logic mem_done = 1'b0;
  logic [7:0] mem_rdata = 8'hf0;
  logic [31:0] rf [8] = '{default: 32'h0000_0000};
  logic [2:0] rf_raddr_a, rf_raddr_b, rf_waddr;
  wire logic [31:0] rf_rdata_a = rf[rf_raddr_a];
  wire logic [31:0] rf_rdata_b = rf[rf_raddr_b];
  logic op_ready, ext_req, illegal, rf_we, sp_we, mem_req, mem_write, ccr_we, pc_we, done;
  logic [1:0] mem_size, g_ws, g_rs;
  logic [31:0] rf_wdata, sp_wdata, mem_addr, mem_wdata, pc_out, g_rf, g_sp, g_pc, g_wa, g_wd, g_ra;
  logic [4:0] ccr_out, g_ccr;
  logic [15:0] xq [$];
  int error_cnt = 0;
  int checks_done = 0;
  int mcnt = 0;
  int lat = 0;
  // n: 0 reg writes, 1 flag writes, 2 sp, 3 pc, 4 refused, 5 done, 6 reads, 7 writes, 8 accesses, 9/10 read/write slot
  int n [11] = '{default: 0};
  bssb_core u_bssb_core (.*);
  always #10 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////
  // far side: words and memory answers change only at the falling edge
  always @(negedge clk) begin
    if (ext_valid) void'(xq.pop_front());
    ext_valid = ext_req && xq.size() > 0;
    // an idle word toggles so a stale sample never looks right
    ext_word = xq.size() > 0 ? xq[0] : ~ext_word;
    // restart the count whenever no request stands, so a reset never leaves a stale count
    if (mem_done || !mem_req) mcnt = 0;
    else mcnt++;
    mem_done = mem_req && !mem_done && mcnt > lat;
    if (mem_done) begin
      n[8]++;
      if (mem_write) begin
        n[7]++;
        n[10] = n[8];
        g_wa = mem_addr;
        g_wd = mem_wdata;
        g_ws = mem_size;
      end else begin
        n[6]++;
        n[9] = n[8];
        g_ra = mem_addr;
        g_rs = mem_size;
      end
    end
    n[0] += rf_we;
    n[1] += ccr_we;
    n[2] += sp_we;
    n[3] += pc_we;
    n[4] += illegal;
    n[5] += done;
    if (rf_we) g_rf = rf_wdata;
    if (ccr_we) g_ccr = ccr_out;
    if (sp_we) g_sp = sp_wdata;
    if (pc_we) g_pc = pc_out;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    if (error_cnt == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic timeout_if(input logic hit);
    if (hit) begin
      error_cnt++;
      tally_and_finish;
    end
  endtask
  // one instruction: offer it, wait for the take, then for done
  task automatic run(input logic [15:0] op, input int mlat);
    int i;
    n = '{default: 0};
    // unknown captures so a missing write never passes on an older value
    {g_rf, g_sp, g_pc, g_wa, g_wd, g_ra, g_ccr, g_ws, g_rs} = 'x;
    lat = mlat;
    op_word = op;
    op_valid = 1'b1;
    for (i = 0; i < 20 && op_ready !== 1'b1; i++) @(negedge clk);
    timeout_if(i == 20);
    @(negedge clk);
    op_valid = 1'b0;
    for (i = 0; i < 80 && done !== 1'b1; i++) @(negedge clk);
    timeout_if(i == 80);
    @(negedge clk);
    xq.delete();
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic s_reg(input int bn, input logic [31:0] dst, input logic [4:0] cin, input logic [31:0] exp,
    input logic [4:0] ecc);
    rf[2] = bn;
    rf[5] = dst;
    ccr_in = cin;
    run(16'h05c5, 0);
    chk("reg_data", g_rf, exp);
    chk("reg_dest", {29'h0, rf_waddr}, 32'h0000_0005);
    chk("reg_flags", g_ccr, ecc);
    chk("reg_no_mem", n[8], 0);
  endtask
  task automatic s_ea;
    logic [5:0] eas [12] = '{6'h01, 6'h08, 6'h13, 6'h1b, 6'h23, 6'h2b, 6'h33, 6'h38, 6'h39, 6'h3a, 6'h3b, 6'h3c};
    logic ok;
    int k;
    ccr_in = 5'h1b;
    rf[1] = 32'h0000_0000;
    rf[3] = 32'h0000_000b;
    for (k = 0; k < 12; k++) begin
      ok = eas[k][5:3] != 3'h1 && !(eas[k][5:3] == 3'h7 && eas[k][2:0] > 3'h1);
      xq.push_back(16'h000b);
      // odd entries take the bit number from a data register instead of the extension word
      run(k % 2 ? {7'h03, 3'h7, eas[k]} : {10'h023, eas[k]}, 2);
      chk("refused", n[4], !ok);
      if (!ok) chk("refused_quiet", n[0] + n[1] + n[7], 0);
      else if (k == 0) chk("dreg_bit", g_rf, 32'h0000_0800);
      else begin
        chk("reads", n[6], 1);
        chk("write_after", n[10], n[9] + 1);
        chk("read_addr", g_ra, ea_addr);
        chk("write_addr", g_wa, ea_addr);
        chk("sizes", {g_rs, g_ws}, 0);
        chk("byte", g_wd[7:0], 8'hf8);
      end
      if (ok) chk("flags", g_ccr, 5'h1f);
    end
  endtask
  task automatic s_ext_bad;
    xq.push_back(16'h010b);
    run(16'h08d3, 0);
    chk("ext_refused", n[4], 1);
    chk("ext_quiet", n[1] + n[7], 0);
    run(16'h6200, 0);
    chk("unknown_refused", n[4], 1);
  endtask
  // reset in the middle of a push: everything drops, ready returns one edge after release
  task automatic s_reset;
    int i;
    lat = 40;
    op_word = 16'h6110;
    op_valid = 1'b1;
    @(negedge clk);
    op_valid = 1'b0;
    for (i = 0; i < 20 && mem_req !== 1'b1; i++) @(negedge clk);
    timeout_if(i == 20);
    resetn = 1'b0;
    @(negedge clk);
    chk("rst_outputs", {op_ready, ext_req, illegal, rf_we, sp_we, mem_req, mem_write, ccr_we, pc_we, done}, 0);
    resetn = 1'b1;
    @(negedge clk);
    chk("rst_idle", {op_ready, mem_req, done}, 3'b100);
  endtask
  task automatic s_branch;
    logic [15:0] ds [5] = '{16'h6110, 16'h61fe, 16'h6100, 16'h6100, 16'h61ff};
    logic [15:0] xs [5] = '{16'h0000, 16'h0000, 16'h0000, 16'hff00, 16'h0001};
    logic [31:0] d, ret;
    int k;
    for (k = 0; k < 5; k++) begin
      d = {{24{ds[k][7]}}, ds[k][7:0]};
      ret = 32'h0000_1002;
      if (ds[k][7:0] == 8'h00) d = {{16{xs[k][15]}}, xs[k]};
      if (ds[k][7:0] == 8'h00) ret = 32'h0000_1004;
      if (ds[k][7:0] == 8'hff) d = {xs[k], 16'h0004};
      if (ds[k][7:0] == 8'hff) ret = 32'h0000_1006;
      xq.push_back(xs[k]);
      xq.push_back(16'h0004);
      run(ds[k], k);
      chk("new_sp", g_sp, 32'h0000_7ffc);
      chk("push_addr", g_wa, 32'h0000_7ffc);
      chk("push_data", g_wd, ret);
      chk("push_size", g_ws, 2);
      chk("target", g_pc, 32'h0000_1002 + d);
      chk("flags_kept", n[1], 0);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(negedge clk);
    resetn = 1'b1;
    repeat (2) @(negedge clk);
    s_reg(37, 32'h1234_0000, 5'h1b, 32'h1234_0020, 5'h1f);
    s_reg(31, 32'h8000_0000, 5'h04, 32'h8000_0000, 5'h00);
    s_reg(64, 32'h0000_0000, 5'h15, 32'h0000_0001, 5'h15);
    s_ea;
    s_ext_bad;
    s_branch;
    s_reset;
    s_reg(5, 32'h0000_0020, 5'h04, 32'h0000_0020, 5'h00);
    tally_and_finish;
  end
endmodule
`default_nettype wire
